// ### inc/line_test_scrambler_consts.svh
// constants of the line test and scrambler register bank
// ****************************************************************
// Summary of operation
// - capture the command bits echoed by the addressed channel after a read request
// - echo capture is read-only, low half at D0B2, high half at D0B3
// - echoed command values become readable after the next frame sync
// - one loop-test bit per channel, 24 channels, set means loop-back test
// - looped channel expects receive frame start shortly after transmit start
// - loop closes only when loop-test bit and command loop bit are both set
// - two-bit method: 00 V.27, 01 legacy, 10 subscriber scrambler, 11 none
// - indication mode 0: no scramble done flag, descramble starts on frame sync rise
// - indication mode 1: status reports done, descramble starts on status write
// - write 0 to bit0 starts descrambling in indication mode; reads 0 while busy
// - write 1 to bit0 starts scrambling; bit0 reads 1 when descrambling done
// - in indication mode bit1 reads 0 while scrambling, 1 when finished
// ****************************************************************
`ifndef LINE_TEST_SCRAMBLER_CONSTS_SVH
`define LINE_TEST_SCRAMBLER_CONSTS_SVH
// register indexes, byte address is four times the index
`define LTS_IDX_SCR_MODE 16'hD010
`define LTS_IDX_SCR_STAT 16'hD011
`define LTS_IDX_ECHO_LO 16'hD0B2
`define LTS_IDX_ECHO_HI 16'hD0B3
`define LTS_IDX_LOOP_LO 16'hD0B4
`define LTS_IDX_LOOP_HI 16'hD0B5
`define LTS_IDX_IRQ_STAT 16'hD0C0
`define LTS_IDX_IRQ_MASK 16'hD0C1
// reset values
`define LTS_RST_SCR_MODE 3'h3
`define LTS_RST_ECHO 32'h0000_0000
`define LTS_RST_LOOP 24'h00_0000
// field positions
`define LTS_BIT_IND_MODE 2
`define LTS_BIT_DESCR 0
`define LTS_BIT_SCR 1
`define LTS_BIT_CMD_RD 1
`define LTS_BIT_CMD_WR 0
`define LTS_BIT_CMD_LOOP 17
`define LTS_POS_CHADR 26
`define LTS_POS_VIPADR 29
// interrupt status bits
`define LTS_IRQ_ECHO 0
`define LTS_IRQ_SCR 1
`define LTS_IRQ_DESCR 2
`define LTS_IRQ_RXTIME 3
// timing
`define LTS_CLK_MHZ 50
`define LTS_NORMAL_RX_US 125
`define LTS_LOOP_RX_MAX_NS 2000
`define LTS_CLK_NS 20
`endif

// ### inc/line_test_scrambler_pkg.sv
// types of the line test and scrambler register bank
package line_test_scrambler_pkg;
    // command word sent to a transceiver channel
    typedef struct packed {
        logic valid;
        logic [31:0] word;
    } cmd_event_t;
    // receive frame start seen on a channel
    typedef struct packed {
        logic valid;
        logic [4:0] chan;
    } rx_start_t;
    typedef enum logic [1:0] {
        SCR_V27 = 2'h0,
        SCR_LEGACY = 2'h1,
        SCR_SUBSCRIBER = 2'h2,
        SCR_NONE = 2'h3
    } scr_method_t;
    typedef enum logic [1:0] {
        ENG_IDLE = 2'h0,
        ENG_BUSY = 2'h1
    } eng_state_t;
endpackage : line_test_scrambler_pkg

// ### verilog/line_test_scrambler_regs.sv
// apb register bank for channel echo capture, loop test and scrambler sequencing
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "line_test_scrambler_consts.svh"
module line_test_scrambler_regs #(
    parameter int CHANNELS = 24,
    parameter int APB_AW = 18,
    parameter int NORMAL_RX_CYCLES = `LTS_NORMAL_RX_US * `LTS_CLK_MHZ
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // link side
    input wire logic i_frame_sync,
    input wire line_test_scrambler_pkg::cmd_event_t i_cmd,
    input wire logic [31:0] i_echo_word,
    input wire line_test_scrambler_pkg::rx_start_t i_rx_start,
    // scrambler engine
    output line_test_scrambler_pkg::scr_method_t o_scramble_method,
    output logic o_indication_mode,
    output logic o_scr_start,
    output logic o_descr_start,
    input wire logic i_scr_done,
    input wire logic i_descr_done,
    // loop test
    output logic [CHANNELS-1:0] o_loop_test_bits,
    output logic [CHANNELS-1:0] o_loop_closed,
    // interrupt
    output logic o_irq
);
    import line_test_scrambler_pkg::*;

    localparam int LOOP_RX_CYCLES_I = `LTS_LOOP_RX_MAX_NS / `LTS_CLK_NS;
    localparam logic [15:0] LOOP_RX_CYCLES = LOOP_RX_CYCLES_I[15:0];
    localparam logic [15:0] NORMAL_CYC = NORMAL_RX_CYCLES[15:0];
    localparam int IW = APB_AW - 2;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    logic [IW-1:0] idx;
    logic hit_mode, hit_stat, hit_elo, hit_ehi, hit_llo, hit_lhi;
    logic hit_ist, hit_imsk, mapped;
    logic wr_en, rd_setup;

    assign idx = i_paddr[APB_AW-1:2];
    assign hit_mode = idx == IW'(`LTS_IDX_SCR_MODE);
    assign hit_stat = idx == IW'(`LTS_IDX_SCR_STAT);
    assign hit_elo = idx == IW'(`LTS_IDX_ECHO_LO);
    assign hit_ehi = idx == IW'(`LTS_IDX_ECHO_HI);
    assign hit_llo = idx == IW'(`LTS_IDX_LOOP_LO);
    assign hit_lhi = idx == IW'(`LTS_IDX_LOOP_HI);
    assign hit_ist = idx == IW'(`LTS_IDX_IRQ_STAT);
    assign hit_imsk = idx == IW'(`LTS_IDX_IRQ_MASK);
    assign mapped = (hit_mode | hit_stat | hit_elo | hit_ehi | hit_llo | hit_lhi
                     | hit_ist | hit_imsk) & (i_paddr[1:0] == 2'h0);
    // zero wait states: every access completes in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;
    assign wr_en = i_psel & i_penable & i_pwrite & mapped;
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;

    // ****************************************************************
    // frame sync synchroniser
    // ****************************************************************
    logic fs_meta, fs_sync, fs_last, fs_rise;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fs_meta <= 1'b0;
            fs_sync <= 1'b0;
            fs_last <= 1'b0;
        end else begin
            fs_meta <= i_frame_sync;
            fs_sync <= fs_meta;
            fs_last <= fs_sync;
        end
    end
    assign fs_rise = fs_sync & ~fs_last;

    // ****************************************************************
    // command echo capture
    // ****************************************************************
    logic read_pending, echo_event;
    logic [31:0] echo_capture;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            read_pending <= 1'b0;
        end else if (i_cmd.valid && i_cmd.word[`LTS_BIT_CMD_RD]) begin
            read_pending <= 1'b1;
        end else if (fs_rise) begin
            read_pending <= 1'b0;
        end
    end
    // echo of a request sent in the previous frame is taken at frame sync
    assign echo_event = fs_rise & read_pending;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            echo_capture <= `LTS_RST_ECHO;
        end else if (echo_event) begin
            echo_capture <= i_echo_word;
        end
    end

    // ****************************************************************
    // loop test
    // ****************************************************************
    logic [CHANNELS-1:0] loop_test_bits;
    logic [CHANNELS-1:0] cmd_loop;
    logic [4:0] cmd_chan;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            loop_test_bits <= CHANNELS'(`LTS_RST_LOOP);
        end else if (wr_en && hit_llo) begin
            loop_test_bits[15:0] <= i_pwdata[15:0];
        end else if (wr_en && hit_lhi) begin
            loop_test_bits[CHANNELS-1:16] <= i_pwdata[CHANNELS-17:0];
        end
    end

    assign cmd_chan = {i_cmd.word[`LTS_POS_VIPADR +: 2], i_cmd.word[`LTS_POS_CHADR +: 3]};

    // remember the loop bit last sent with a valid configuration to each channel
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    cmd_loop[ch] <= 1'b0;
                end else if (i_cmd.valid && i_cmd.word[`LTS_BIT_CMD_WR]
                             && cmd_chan == 5'(ch)) begin
                    cmd_loop[ch] <= i_cmd.word[`LTS_BIT_CMD_LOOP];
                end
            end
            assign o_loop_closed[ch] = loop_test_bits[ch] & cmd_loop[ch];
        end
    endgenerate
    assign o_loop_test_bits = loop_test_bits;

    // ****************************************************************
    // receive frame start timing
    // ****************************************************************
    logic [15:0] since_tx;
    logic rx_in_loop, rx_time_err;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            since_tx <= 16'h0000;
        end else if (fs_rise) begin
            since_tx <= 16'h0000;
        end else if (since_tx != 16'hFFFF) begin
            since_tx <= since_tx + 16'h0001;
        end
    end
    // out-of-range channels count as normal mode
    assign rx_in_loop = (i_rx_start.chan < 5'(CHANNELS)) && loop_test_bits[i_rx_start.chan];
    // looped channel must start early, a normal one not before the frame time
    assign rx_time_err = i_rx_start.valid &&
        (rx_in_loop ? (since_tx > LOOP_RX_CYCLES) : (since_tx < NORMAL_CYC));

    // ****************************************************************
    // scrambler mode and sequencing
    // ****************************************************************
    logic [2:0] scr_mode;
    logic ind_mode;
    logic start_scr, start_descr;
    eng_state_t scr_state, next_scr_state;
    eng_state_t descr_state, next_descr_state;
    logic scr_event, descr_event;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scr_mode <= `LTS_RST_SCR_MODE;
        end else if (wr_en && hit_mode) begin
            scr_mode <= i_pwdata[2:0];
        end
    end
    assign ind_mode = scr_mode[`LTS_BIT_IND_MODE];
    assign o_scramble_method = scr_method_t'(scr_mode[1:0]);
    assign o_indication_mode = ind_mode;

    assign start_scr = wr_en && hit_stat && i_pwdata[`LTS_BIT_DESCR];
    // a software descramble start is ignored outside indication mode
    assign start_descr = ind_mode
        ? (wr_en && hit_stat && !i_pwdata[`LTS_BIT_DESCR])
        : fs_rise;

    always_comb begin
        next_scr_state = scr_state;
        case (scr_state)
            ENG_IDLE: if (start_scr) next_scr_state = ENG_BUSY;
            ENG_BUSY: if (i_scr_done) next_scr_state = ENG_IDLE;
            default: next_scr_state = ENG_IDLE;
        endcase
    end

    always_comb begin
        next_descr_state = descr_state;
        case (descr_state)
            ENG_IDLE: if (start_descr) next_descr_state = ENG_BUSY;
            ENG_BUSY: if (i_descr_done) next_descr_state = ENG_IDLE;
            default: next_descr_state = ENG_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scr_state <= ENG_IDLE;
            descr_state <= ENG_IDLE;
        end else begin
            scr_state <= next_scr_state;
            descr_state <= next_descr_state;
        end
    end

    // starts while the engine is still busy are dropped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_scr_start <= 1'b0;
            o_descr_start <= 1'b0;
        end else begin
            o_scr_start <= start_scr && scr_state == ENG_IDLE;
            o_descr_start <= start_descr && descr_state == ENG_IDLE;
        end
    end

    assign scr_event = scr_state == ENG_BUSY && i_scr_done;
    assign descr_event = descr_state == ENG_BUSY && i_descr_done;

    // ****************************************************************
    // interrupts
    // ****************************************************************
    logic [3:0] irq_stat, irq_mask, irq_set;

    assign irq_set = {rx_time_err, descr_event & ind_mode, scr_event & ind_mode, echo_event};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_stat <= 4'h0;
        end else begin
            // a new event wins over a simultaneous clear
            irq_stat <= (irq_stat & ~((wr_en && hit_ist) ? i_pwdata[3:0] : 4'h0)) | irq_set;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_mask <= 4'h0;
        end else if (wr_en && hit_imsk) begin
            irq_mask <= i_pwdata[3:0];
        end
    end
    assign o_irq = |(irq_stat & irq_mask);

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [31:0] next_rdata;
    logic [1:0] stat_rd;

    // done flags read as the engines being idle; bit1 only in indication mode
    assign stat_rd = {ind_mode & (scr_state == ENG_IDLE), descr_state == ENG_IDLE};

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_mode) next_rdata[2:0] = scr_mode;
        if (hit_stat) next_rdata[1:0] = stat_rd;
        if (hit_elo) next_rdata[15:0] = echo_capture[15:0];
        if (hit_ehi) next_rdata[15:0] = echo_capture[31:16];
        if (hit_llo) next_rdata[15:0] = loop_test_bits[15:0];
        if (hit_lhi) next_rdata[CHANNELS-17:0] = loop_test_bits[CHANNELS-1:16];
        if (hit_ist) next_rdata[3:0] = irq_stat;
        if (hit_imsk) next_rdata[3:0] = irq_mask;
    end

    // sampled in the setup cycle so the access phase sees flop data
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            o_prdata <= (i_paddr[1:0] == 2'h0) ? next_rdata : 32'h0000_0000;
        end
    end
endmodule : line_test_scrambler_regs

// ### bench/lts_regs_properties.sv
// port assertions of the line test and scrambler register bank
`timescale 1ns/10ps
`include "line_test_scrambler_consts.svh"
module lts_regs_checker
import line_test_scrambler_pkg::*;
#(
    parameter int CHANNELS = 24,
    parameter int APB_AW = 18
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    // engines and loops
    input wire line_test_scrambler_pkg::scr_method_t o_scramble_method,
    input wire logic o_indication_mode,
    input wire logic o_scr_start,
    input wire logic o_descr_start,
    input wire logic [CHANNELS-1:0] o_loop_test_bits,
    input wire logic [CHANNELS-1:0] o_loop_closed
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic stat_wr;
    assign stat_wr = i_psel && i_penable && i_pwrite
        && i_paddr[APB_AW-1:2] == `LTS_IDX_SCR_STAT;
    a_slverr_access: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slave error outside an access phase");
    a_unmapped_err: assert property (i_psel && i_penable && i_paddr[APB_AW-1:2] == 16'h0 |-> o_pslverr)
        else $error("unmapped access not refused");
    a_rdata_holds: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data moved outside a read setup");
    a_scr_cause: assert property (o_scr_start |-> $past(stat_wr && i_pwdata[0]))
        else $error("scramble start without a status write of one");
    a_scr_pulse: assert property (o_scr_start |=> !o_scr_start)
        else $error("scramble start longer than one cycle");
    a_descr_cause: assert property (o_descr_start && o_indication_mode && $past(o_indication_mode, 2)
        |-> $past(stat_wr && !i_pwdata[0]))
        else $error("descramble start without a status write of zero");
    a_loop_gated: assert property ((o_loop_closed & ~o_loop_test_bits) == '0)
        else $error("loop closed without its test bit");
    a_mode_reset: assert property ($fell(i_rst) |-> o_scramble_method == SCR_NONE && !o_indication_mode)
        else $error("mode not at reset value");
    c_scr: cover property (o_scr_start);
    c_descr: cover property (o_descr_start);
    c_loop: cover property (|o_loop_closed);
endmodule : lts_regs_checker
bind line_test_scrambler_regs lts_regs_checker #(.CHANNELS(CHANNELS), .APB_AW(APB_AW)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_scramble_method(o_scramble_method), .o_indication_mode(o_indication_mode),
    .o_scr_start(o_scr_start), .o_descr_start(o_descr_start),
    .o_loop_test_bits(o_loop_test_bits), .o_loop_closed(o_loop_closed));

// ### bench/engine_partner.sv
// behavioural engines and echoing transceiver on the far side
`timescale 1ns/10ps
module engine_partner
import line_test_scrambler_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_scr_start,
    input wire logic i_descr_start,
    input wire line_test_scrambler_pkg::cmd_event_t i_cmd,
    output logic o_scr_done,
    output logic o_descr_done,
    output logic [31:0] o_echo_word
);
    import line_test_scrambler_pkg::*;
    int scr_cnt;
    int descr_cnt;
    logic armed;
    logic [31:0] echo_cmd;
    logic [31:0] status_pat;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scr_cnt <= 0;
            descr_cnt <= 0;
            o_scr_done <= 1'b0;
            o_descr_done <= 1'b0;
        end else begin
            o_scr_done <= scr_cnt == 1;
            o_descr_done <= descr_cnt == 1;
            scr_cnt <= i_scr_start ? (i_slow ? 12 : 1) : (scr_cnt > 0 ? scr_cnt - 1 : 0);
            descr_cnt <= i_descr_start ? (i_slow ? 12 : 1) : (descr_cnt > 0 ? descr_cnt - 1 : 0);
        end
    end
    // normal status keeps changing so a stale capture is seen
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            armed <= 1'b0;
            echo_cmd <= 32'h0;
            status_pat <= 32'h5A5A_A5A5;
        end else begin
            status_pat <= status_pat + 32'h1357_9BDF;
            if (i_cmd.valid && i_cmd.word[1]) begin
                armed <= 1'b1;
                echo_cmd <= i_cmd.word;
            end
        end
    end
    assign o_echo_word = armed ? echo_cmd : status_pat;
endmodule : engine_partner

// ### bench/testbench.sv
// self-checking bench of the line test and scrambler register bank
`timescale 1ns/10ps
module testbench;
    import line_test_scrambler_pkg::*;
    logic clk = 1'b0, rst, psel, penable, pwrite, pready, pslverr, fs, slow, irq;
    logic scr_start, descr_start, scr_done, descr_done, ind;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, echo_word, d, w, seed;
    logic [23:0] loop_bits, loop_closed;
    cmd_event_t cmd;
    rx_start_t rxs;
    scr_method_t method;
    logic [32:0] expq[$];
    int n_mismatch = 0, checked = 0, n_descr = 0, n0;
    line_test_scrambler_regs #(.NORMAL_RX_CYCLES(50)) u_dut (.i_clk(clk), .i_rst(rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_frame_sync(fs), .i_cmd(cmd), .i_echo_word(echo_word), .i_rx_start(rxs),
        .o_scramble_method(method), .o_indication_mode(ind), .o_scr_start(scr_start),
        .o_descr_start(descr_start), .i_scr_done(scr_done), .i_descr_done(descr_done),
        .o_loop_test_bits(loop_bits), .o_loop_closed(loop_closed), .o_irq(irq));
    engine_partner u_far (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_scr_start(scr_start),
        .i_descr_start(descr_start), .i_cmd(cmd), .o_scr_done(scr_done),
        .o_descr_done(descr_done), .o_echo_word(echo_word));
    always #10 clk = ~clk;
    task chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // reads note their expectation, the monitor compares
    task apb(input logic wr, input logic [15:0] idx, input logic [31:0] dat, input logic [32:0] e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= dat;
        if (!wr) expq.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so callers look at settled register outputs
        @(posedge clk);
    endtask : apb
    task send_cmd(input logic [31:0] c);
        @(posedge clk);
        cmd <= {1'b1, c};
        @(posedge clk);
        cmd <= '0;
        repeat (2) @(posedge clk);
    endtask : send_cmd
    task send_rx(input logic [4:0] c);
        rxs <= {1'b1, c};
        @(posedge clk);
        rxs <= '0;
        @(posedge clk);
    endtask : send_rx
    task frame;
        fs <= 1'b1;
        repeat (6) @(posedge clk);
        fs <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : frame
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) chk("prdata", {pslverr, prdata}, expq.pop_front());
        if (descr_start === 1'b1) n_descr++;
    end
    initial begin
        #(20 * 20000);
        n_mismatch++;
        print_verdict;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, fs, cmd, slow, seed} = {4'h8, 85'h0, 32'h9BBD};
        slow = 1'b1;
        rxs = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(0, 16'hD010, 0, 33'h3);
        apb(0, 16'hD011, 0, 33'h1);
        apb(0, 16'hD0B3, 0, 33'h0);
        apb(0, 16'hD0B5, 0, 33'h0);
        apb(0, 16'h0000, 0, {1'b1, 32'h0});
        for (int m = 0; m < 4; m++) begin
            d = ($random(seed) & 32'hFFFF_FFF8) | m;
            apb(1, 16'hD010, d, 0);
            apb(0, 16'hD010, 0, {31'h0, d[1:0]});
            chk("method", {31'h0, method}, {31'h0, d[1:0]});
        end
        w = $random(seed) | 32'h20;
        apb(1, 16'hD0B4, w, 0);
        apb(1, 16'hD0B5, w >> 16, 0);
        apb(0, 16'hD0B5, 0, {25'h0, w[23:16]});
        chk("loop_bits", {9'h0, loop_bits}, {9'h0, w[23:0]});
        send_cmd(32'h1402_0001);
        chk("loop_closed", {9'h0, loop_closed}, 33'h20);
        apb(1, 16'hD0B4, w & 32'hFFDF, 0);
        chk("loop_open", {9'h0, loop_closed}, 33'h0);
        apb(1, 16'hD0C1, 32'hF, 0);
        w = $random(seed) | 32'h2;
        send_cmd(w);
        apb(0, 16'hD0B2, 0, 33'h0);
        chk("irq_early", {32'h0, irq}, 33'h0);
        frame();
        chk("fs_descr", {32'h0, n_descr != 0}, 33'h1);
        chk("irq_echo", {32'h0, irq}, 33'h1);
        apb(1, 16'hD0B2, 32'hFFFF, 0);
        apb(0, 16'hD0B2, 0, {17'h0, w[15:0]});
        apb(0, 16'hD0B3, 0, {17'h0, w[31:16]});
        apb(0, 16'hD0C0, 0, 33'h1);
        apb(1, 16'hD0C0, 32'h1, 0);
        chk("irq_clear", {32'h0, irq}, 33'h0);
        // normal channel starting early is a timing error
        frame();
        send_rx(5'h05);
        apb(0, 16'hD0C0, 0, 33'h8);
        apb(1, 16'hD0C0, 32'h8, 0);
        apb(1, 16'hD0B4, 32'h1, 0);
        frame();
        send_rx(5'h00);
        repeat (100) @(posedge clk);
        send_rx(5'h05);
        apb(0, 16'hD0C0, 0, 33'h0);
        send_rx(5'h00);
        apb(0, 16'hD0C0, 0, 33'h8);
        apb(1, 16'hD0C0, 32'h8, 0);
        // indication mode bit 2 is set by software before scrambling
        apb(1, 16'hD010, 32'h4, 0);
        chk("ind_mode", {32'h0, ind}, 33'h1);
        apb(1, 16'hD011, 32'h1, 0);
        apb(0, 16'hD011, 0, 33'h1);
        repeat (20) @(posedge clk);
        apb(0, 16'hD011, 0, 33'h3);
        chk("irq_scr", {32'h0, irq}, 33'h1);
        apb(1, 16'hD011, 32'h0, 0);
        apb(0, 16'hD011, 0, 33'h2);
        repeat (20) @(posedge clk);
        apb(0, 16'hD011, 0, 33'h3);
        n0 = n_descr;
        frame();
        chk("fs_ignored", {32'h0, n_descr == n0}, 33'h1);
        apb(0, 16'hD0C0, 0, 33'h6);
        slow <= 1'b0;
        apb(1, 16'hD011, 32'h1, 0);
        repeat (5) @(posedge clk);
        apb(0, 16'hD011, 0, 33'h3);
        print_verdict;
    end
endmodule : testbench
